// ===== hdl/brownout_response_control.sv
/*
 * Brown-out response control: AXI4-Lite register slave, protected
 * control fields loaded from the user configuration word, event flag,
 * interrupt latch and chip reset request.
 * Assumes the comparator output and configuration word are synchronous
 * to aclk and the configuration word is valid when reset releases.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brownout_cfg.svh"

module brownout_response_control (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [`BO_ADDR_W-1:0] s_axi_awaddr,
    // axi4-lite write data
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    // axi4-lite write response
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    // axi4-lite read address
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [`BO_ADDR_W-1:0] s_axi_araddr,
    // axi4-lite read data
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    // analog comparator and configuration
    input wire logic comparator_out,
    input wire logic [31:0] user_config_word,
    output logic detector_enable,
    output logic [1:0] brownout_threshold_sel,
    // system outputs
    output logic brownout_irq,
    output logic chip_reset_req,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////
    // write channel state
    logic aw_held_ff;
    logic nxt_aw_held;
    logic [`BO_ADDR_W-1:0] aw_addr_ff;
    logic [`BO_ADDR_W-1:0] nxt_aw_addr;
    logic w_held_ff;
    logic nxt_w_held;
    logic [31:0] w_data_ff;
    logic [31:0] nxt_w_data;
    logic w_lane0_ff;
    logic nxt_w_lane0;
    logic bvalid_ff;
    logic nxt_bvalid;
    logic [1:0] bresp_ff;
    logic [1:0] nxt_bresp;
    logic wr_do;
    logic awready_ff, nxt_awready;
    logic wready_ff, nxt_wready;

    // read channel state
    logic rvalid_ff;
    logic nxt_rvalid;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    logic [1:0] rresp_ff;
    logic [1:0] nxt_rresp;
    logic rd_do;
    logic arready_ff, nxt_arready;

    // brown-out state
    logic load_cfg_ff;
    logic enable_ff;
    logic nxt_enable;
    logic [1:0] thr_ff;
    logic [1:0] nxt_thr;
    logic rst_sel_ff;
    logic nxt_rst_sel;
    logic event_ff;
    logic nxt_event;
    logic comp_prev_ff;
    logic nxt_comp_prev;
    logic alarm_ff;
    logic nxt_alarm;
    logic reset_req_ff;
    logic nxt_reset_req;
    logic mask_ff;
    logic nxt_mask;
    logic irq_ff;
    logic nxt_irq;

    // register write decode
    logic unlocked;
    logic wr_ctrl;
    logic wr_mask;
    logic wr_unlock;
    logic comp_seen;

    ////////////////////////////////////////////////////////////////////
    // write path: address and data taken in either order, then one
    // response; the slave holds both until the response is accepted
    assign wr_do = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_ctrl = wr_do && w_lane0_ff
                     && (aw_addr_ff == `BO_OFS_CONTROL);
    assign wr_mask = wr_do && w_lane0_ff
                     && (aw_addr_ff == `BO_OFS_INT_MASK);
    assign wr_unlock = wr_do && w_lane0_ff
                       && (aw_addr_ff == `BO_OFS_UNLOCK);

    always_comb begin
        nxt_aw_held = aw_held_ff;
        nxt_aw_addr = aw_addr_ff;
        nxt_w_held = w_held_ff;
        nxt_w_data = w_data_ff;
        nxt_w_lane0 = w_lane0_ff;
        nxt_bvalid = bvalid_ff;
        nxt_bresp = bresp_ff;
        if (s_axi_awvalid && !aw_held_ff) begin
            nxt_aw_held = 1'b1;
            nxt_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_held_ff) begin
            nxt_w_held = 1'b1;
            nxt_w_data = s_axi_wdata;
            nxt_w_lane0 = s_axi_wstrb[0];
        end
        if (wr_do) begin
            nxt_bvalid = 1'b1;
            case (aw_addr_ff)
                `BO_OFS_CONTROL,
                `BO_OFS_INT_MASK,
                `BO_OFS_UNLOCK: nxt_bresp = `BO_RESP_OKAY;
                default: nxt_bresp = `BO_RESP_SLVERR;
            endcase
        end
        if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
            nxt_aw_held = 1'b0;
            nxt_w_held = 1'b0;
        end
        nxt_awready = !nxt_aw_held;
        nxt_wready = !nxt_w_held;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0;
            w_lane0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `BO_RESP_OKAY;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
        end else begin
            aw_held_ff <= nxt_aw_held;
            aw_addr_ff <= nxt_aw_addr;
            w_held_ff <= nxt_w_held;
            w_data_ff <= nxt_w_data;
            w_lane0_ff <= nxt_w_lane0;
            bvalid_ff <= nxt_bvalid;
            bresp_ff <= nxt_bresp;
            awready_ff <= nxt_awready;
            wready_ff <= nxt_wready;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read path: one read under way, answered the cycle after arvalid
    assign rd_do = s_axi_arvalid && !rvalid_ff;

    always_comb begin
        nxt_rvalid = rvalid_ff;
        nxt_rdata = rdata_ff;
        nxt_rresp = rresp_ff;
        if (rd_do) begin
            nxt_rvalid = 1'b1;
            nxt_rdata = 32'h0;
            nxt_rresp = `BO_RESP_OKAY;
            case (s_axi_araddr)
                `BO_OFS_CONTROL: begin
                    nxt_rdata[`BO_BIT_ENABLE] = enable_ff;
                    nxt_rdata[`BO_BIT_THR_HI:`BO_BIT_THR_LO] = thr_ff;
                    nxt_rdata[`BO_BIT_RST_SEL] = rst_sel_ff;
                    nxt_rdata[`BO_BIT_EVENT] = event_ff;
                    // live comparator, forced low when off
                    nxt_rdata[`BO_BIT_STATUS] = comparator_out && enable_ff;
                end
                `BO_OFS_INT_MASK: begin
                    nxt_rdata[`BO_BIT_EVENT] = mask_ff;
                end
                `BO_OFS_UNLOCK: begin
                    nxt_rdata[0] = unlocked;
                end
                default: begin
                    nxt_rresp = `BO_RESP_SLVERR;
                end
            endcase
        end else if (rvalid_ff && s_axi_rready) begin
            nxt_rvalid = 1'b0;
        end
        nxt_arready = !nxt_rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h0;
            rresp_ff <= `BO_RESP_OKAY;
            arready_ff <= 1'b1;
        end else begin
            rvalid_ff <= nxt_rvalid;
            rdata_ff <= nxt_rdata;
            rresp_ff <= nxt_rresp;
            arready_ff <= nxt_arready;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // unlock sequencer on the low byte of the unlock register
    write_unlock u_unlock (
        .aclk(aclk),
        .aresetn(aresetn),
        .wr_pulse(wr_unlock),
        .wr_byte(w_data_ff[7:0]),
        .unlocked_ff(unlocked)
    );

    ////////////////////////////////////////////////////////////////////
    // control fields: loaded from the configuration word in the first
    // cycle after reset, since a synchronous reset must load constants
    assign comp_seen = comparator_out && enable_ff;

    always_comb begin
        nxt_enable = enable_ff;
        nxt_thr = thr_ff;
        nxt_rst_sel = rst_sel_ff;
        nxt_mask = mask_ff;
        if (load_cfg_ff) begin
            nxt_enable = user_config_word[`BO_CFG_ENABLE];
            nxt_rst_sel = user_config_word[`BO_CFG_RST_SEL];
            nxt_thr = user_config_word[`BO_CFG_THR_HI:`BO_CFG_THR_LO];
        end else if (wr_ctrl && unlocked) begin
            // protected fields change only while unlocked
            nxt_enable = w_data_ff[`BO_BIT_ENABLE];
            nxt_thr = w_data_ff[`BO_BIT_THR_HI:`BO_BIT_THR_LO];
            nxt_rst_sel = w_data_ff[`BO_BIT_RST_SEL];
        end
        if (wr_mask) begin
            nxt_mask = w_data_ff[`BO_BIT_EVENT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_cfg_ff <= 1'b1;
            enable_ff <= 1'b0;
            thr_ff <= brownout_pkg::THR_2V2;
            rst_sel_ff <= 1'b0;
            mask_ff <= `BO_MASK_RESET;
        end else begin
            load_cfg_ff <= 1'b0;
            enable_ff <= nxt_enable;
            thr_ff <= nxt_thr;
            rst_sel_ff <= nxt_rst_sel;
            mask_ff <= nxt_mask;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // event flag, interrupt latch, reset request and masked interrupt
    always_comb begin
        nxt_comp_prev = comp_seen;
        nxt_event = event_ff;
        // clear on a one, keep on a zero; locked writes still reach
        // this bit since it is unprotected
        if (wr_ctrl && w_data_ff[`BO_BIT_EVENT]) begin
            nxt_event = 1'b0;
        end
        // a crossing in either direction sets; set beats clear
        if (enable_ff && (comparator_out != comp_prev_ff)) begin
            nxt_event = 1'b1;
        end
        nxt_alarm = alarm_ff;
        if (!enable_ff) begin
            nxt_alarm = 1'b0; // held until enable drops
        end else if (!rst_sel_ff && comparator_out) begin
            nxt_alarm = 1'b1;
        end
        // reset request follows the comparator while armed
        nxt_reset_req = enable_ff && rst_sel_ff && comparator_out;
        // delivery can also be blocked upstream
        nxt_irq = nxt_event && mask_ff;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            comp_prev_ff <= 1'b0;
            event_ff <= 1'b0;
            alarm_ff <= 1'b0;
            reset_req_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            comp_prev_ff <= nxt_comp_prev;
            event_ff <= nxt_event;
            alarm_ff <= nxt_alarm;
            reset_req_ff <= nxt_reset_req;
            irq_ff <= nxt_irq;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs, all straight from flip-flops
    assign s_axi_awready = awready_ff;
    assign s_axi_wready = wready_ff;
    assign s_axi_bvalid = bvalid_ff;
    assign s_axi_bresp = bresp_ff;
    assign s_axi_arready = arready_ff;
    assign s_axi_rvalid = rvalid_ff;
    assign s_axi_rdata = rdata_ff;
    assign s_axi_rresp = rresp_ff;
    assign detector_enable = enable_ff;
    assign brownout_threshold_sel = thr_ff; // code 3 is 4.4 V
    assign brownout_irq = alarm_ff;
    assign chip_reset_req = reset_req_ff;
    assign irq = irq_ff;

endmodule

`default_nettype wire

// ===== hdl/brownout_cfg.svh
/*
 * Register map, field positions, reset values and unlock key bytes
 * for the brown-out response control block.
 * Assumes a 32-bit AXI4-Lite register bus with byte addressing.
 */
`ifndef BROWNOUT_CFG_SVH
`define BROWNOUT_CFG_SVH

// byte addresses
`define BO_ADDR_W 12
`define BO_OFS_CONTROL 12'h018
`define BO_OFS_INT_MASK 12'h020
`define BO_OFS_UNLOCK 12'h100

// control register fields
`define BO_BIT_ENABLE 0
`define BO_BIT_THR_LO 1
`define BO_BIT_THR_HI 2
`define BO_BIT_RST_SEL 3
`define BO_BIT_EVENT 4
`define BO_BIT_STATUS 6

// user configuration word fields
`define BO_CFG_RST_SEL 20
`define BO_CFG_THR_LO 21
`define BO_CFG_THR_HI 22
`define BO_CFG_ENABLE 23

// reset values
`define BO_MASK_RESET 1'b0

// unlock key sequence
`define BO_KEY_0 8'h59
`define BO_KEY_1 8'h16
`define BO_KEY_2 8'h88

// bus responses
`define BO_RESP_OKAY 2'h0
`define BO_RESP_SLVERR 2'h2

`endif

// ===== hdl/brownout_pkg.sv
/*
 * Types shared by the brown-out response control block.
 * Assumes nothing of its surroundings.
 */
package brownout_pkg;

    // unlock sequence progress, one-hot
    typedef enum logic [3:0] {
        UNLK_IDLE = 4'h1,
        UNLK_KEY1 = 4'h2,
        UNLK_KEY2 = 4'h4,
        UNLK_OPEN = 4'h8
    } unlock_state_type;

    // threshold codes driven to the analog comparator
    typedef enum logic [1:0] {
        THR_2V2 = 2'h0,
        THR_2V7 = 2'h1,
        THR_3V7 = 2'h2,
        THR_4V4 = 2'h3
    } threshold_type;

endpackage

// ===== hdl/write_unlock.sv
/*
 * Unlock sequencer for the protected brown-out fields.
 * Assumes one-cycle write pulses carrying the low byte written to the
 * unlock register; runs on the system clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brownout_cfg.svh"

module write_unlock (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write from the register slave
    input wire logic wr_pulse,
    input wire logic [7:0] wr_byte,
    // protection state
    output logic unlocked_ff
);

    brownout_pkg::unlock_state_type state_ff;
    brownout_pkg::unlock_state_type nxt_state;
    logic nxt_unlocked;

    ////////////////////////////////////////////////////////////////////
    // key matching; a wrong byte restarts, any write when open relocks
    always_comb begin
        nxt_state = state_ff;
        if (wr_pulse) begin
            case (state_ff)
                brownout_pkg::UNLK_IDLE: begin
                    if (wr_byte == `BO_KEY_0) begin
                        nxt_state = brownout_pkg::UNLK_KEY1;
                    end
                end
                brownout_pkg::UNLK_KEY1: begin
                    if (wr_byte == `BO_KEY_1) begin
                        nxt_state = brownout_pkg::UNLK_KEY2;
                    end else begin
                        nxt_state = brownout_pkg::UNLK_IDLE;
                    end
                end
                brownout_pkg::UNLK_KEY2: begin
                    if (wr_byte == `BO_KEY_2) begin
                        nxt_state = brownout_pkg::UNLK_OPEN;
                    end else begin
                        nxt_state = brownout_pkg::UNLK_IDLE;
                    end
                end
                brownout_pkg::UNLK_OPEN: begin
                    nxt_state = brownout_pkg::UNLK_IDLE;
                end
                default: begin
                    nxt_state = brownout_pkg::UNLK_IDLE;
                end
            endcase
        end
        nxt_unlocked = (nxt_state == brownout_pkg::UNLK_OPEN);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_ff <= brownout_pkg::UNLK_IDLE;
            unlocked_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            unlocked_ff <= nxt_unlocked;
        end
    end

endmodule

`default_nettype wire

// ===== sim/brownout_supply_model.sv
/*
 * Behavioural model of the analog brown-out comparator.
 * Assumes the bench sets the supply level in millivolts on aclk edges.
 */
`timescale 1ns/1ps
`default_nettype none

module brownout_supply_model (
    // clock
    input wire logic aclk,
    // settings from the control block
    input wire logic detector_enable,
    input wire logic [1:0] brownout_threshold_sel,
    // supply level from the bench
    input wire logic [15:0] supply_mv,
    // comparator decision
    output logic comparator_out
);
    logic [15:0] trip_mv;

    ////////////////////////////////////////////////////////////////////////
    // trip level per code, code 3 being the highest
    always_comb begin
        case (brownout_threshold_sel)
            brownout_pkg::THR_4V4: trip_mv = 16'h1130;
            brownout_pkg::THR_3V7: trip_mv = 16'h0E74;
            brownout_pkg::THR_2V7: trip_mv = 16'h0A8C;
            default: trip_mv = 16'h0898;
        endcase
    end

    // a disabled comparator is unpowered and reads low
    always_ff @(posedge aclk) begin
        comparator_out <= detector_enable && (supply_mv < trip_mv);
    end
endmodule
`default_nettype wire

// ===== sim/brownout_response_control_sva.sv
/*
 * Checker for the brown-out response control block.
 * Assumes it is bound to the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brownout_cfg.svh"

module brownout_response_control_sva (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus signals watched
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [`BO_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // detector side
    input wire logic comparator_out,
    input wire logic detector_enable,
    input wire logic brownout_irq,
    input wire logic chip_reset_req,
    input wire logic irq
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ////////////////////////////////////////////////////////////////////////
    // bus answers stand until taken
    chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("bvalid dropped");
    chk_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("rvalid dropped");
    chk_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    // status bit is the gated comparator at the read edge
    chk_status_read: assert property ($rose(s_axi_rvalid) &&
        $past(s_axi_araddr) == `BO_OFS_CONTROL |-> s_axi_rdata[6] ==
        $past(comparator_out && detector_enable)) else $error("status bad");
    // reset request only from an enabled low supply
    chk_reset_cause: assert property (chip_reset_req |->
        $past(detector_enable && comparator_out)) else $error("bad reset");
    chk_reset_off: assert property (!detector_enable |=> !chip_reset_req)
        else $error("reset while disabled");
    chk_irq_cause: assert property ($rose(brownout_irq) |->
        $past(detector_enable && comparator_out)) else $error("bad irq");
    // interrupt latch holds while enabled
    chk_irq_hold: assert property (brownout_irq && detector_enable |=>
        brownout_irq) else $error("irq pulsed");
    chk_mode_excl: assert property (!(chip_reset_req && $rose(brownout_irq)))
        else $error("both modes fired");

    cover property ($rose(brownout_irq));
    cover property ($rose(chip_reset_req));
    cover property ($rose(irq));
endmodule

bind brownout_response_control brownout_response_control_sva u_sva (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .comparator_out(comparator_out),
    .detector_enable(detector_enable), .brownout_irq(brownout_irq),
    .chip_reset_req(chip_reset_req), .irq(irq)
);
`default_nettype wire

// ===== sim/tb.sv
/*
 * Self-checking bench: AXI4-Lite register tasks and scenario sequence.
 * Assumes the comparator model and the bound checker are compiled.
 */
`timescale 1ns/1ps
`default_nettype none
`include "brownout_cfg.svh"

module tb;
    logic aclk, aresetn, awv, awr, wv, wrd, bv, bq, arv, arr, rv, rq;
    logic [11:0] aw, ar;
    logic [31:0] wd, rd, cfg;
    logic [1:0] br, rr, thr;
    logic cmp, en, birq, crst, irq;
    logic [15:0] mv;
    logic [3:0] ws;
    int fail_count, cmp_count, cyc;

    brownout_response_control u_brownout_response_control (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_awaddr(aw), .s_axi_wvalid(wv),
        .s_axi_wready(wrd), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_bresp(br),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ar),
        .s_axi_rvalid(rv), .s_axi_rready(rq), .s_axi_rdata(rd),
        .s_axi_rresp(rr), .comparator_out(cmp), .user_config_word(cfg),
        .detector_enable(en), .brownout_threshold_sel(thr),
        .brownout_irq(birq), .chip_reset_req(crst), .irq(irq));

    brownout_supply_model u_brownout_supply_model (.aclk(aclk),
        .detector_enable(en), .brownout_threshold_sel(thr),
        .supply_mv(mv), .comparator_out(cmp));

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, s, e);
        end
    endtask

    // master offers address and data together, releases each when taken
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ad, dd;
        ad = 1'b0;
        dd = 1'b0;
        awv <= 1'b1; aw <= a; wv <= 1'b1; wd <= d;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awv && awr) begin ad = 1'b1; awv <= 1'b0; end
            if (wv && wrd) begin dd = 1'b1; wv <= 1'b0; end
        end
        bq <= 1'b1;
        do @(posedge aclk); while (!bv);
        bq <= 1'b0;
        check(br, 32'h0);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e,
            input logic [1:0] er);
        arv <= 1'b1; ar <= a; rq <= 1'b1;
        do @(posedge aclk); while (!arr);
        arv <= 1'b0;
        // rready is raised by every read and never lowered, so each response is taken as soon as rvalid rises
        do @(posedge aclk); while (!rv);
        check(rd, e);
        check(rr, er);
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // clock, 50 ns period
    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    // hang guard: the sequence needs well under a thousand cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            test_done();
        end
    end

    initial begin
        aresetn = 1'b0; awv = 1'b0; wv = 1'b0; bq = 1'b0; arv = 1'b0;
        rq = 1'b0; aw = 12'h000; ar = 12'h000; wd = 32'h0;
        cfg = 32'h00C00000; mv = 16'h1388; ws = 4'hF;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        // defaults come from the configuration word
        check(en, 1'b1);
        check(thr, 2'h2);
        rdc(12'h018, 32'h5, 2'h0);
        rdc(12'h020, 32'h0, 2'h0);
        rdc(12'h004, 32'h0, 2'h2);
        $display("defaults done");
        // locked and wrong-order writes leave protected fields alone
        wr(12'h018, 32'h0);
        rdc(12'h018, 32'h5, 2'h0);
        wr(12'h100, 32'h59); wr(12'h100, 32'h88); wr(12'h100, 32'h16);
        rdc(12'h100, 32'h0, 2'h0);
        wr(12'h100, 32'h59); wr(12'h100, 32'h16); wr(12'h100, 32'h88);
        rdc(12'h100, 32'h1, 2'h0);
        wr(12'h018, 32'h7);
        check(thr, 2'h3);
        $display("protection done");
        // low supply in interrupt mode
        wr(12'h020, 32'h10);
        mv <= 16'h0FA0;
        repeat (4) @(posedge aclk);
        check(birq, 1'b1);
        check(irq, 1'b1);
        check(crst, 1'b0);
        wr(12'h100, 32'h0);
        wr(12'h018, 32'h0);
        rdc(12'h018, 32'h57, 2'h0);
        wr(12'h018, 32'h10);
        rdc(12'h018, 32'h47, 2'h0);
        check(irq, 1'b0);
        mv <= 16'h1388;
        repeat (4) @(posedge aclk);
        rdc(12'h018, 32'h17, 2'h0);
        check(birq, 1'b1);
        wr(12'h020, 32'h0);
        repeat (2) @(posedge aclk);
        check(irq, 1'b0);
        // a write without byte lane 0 must leave the mask alone
        ws <= 4'hE;
        wr(12'h020, 32'h10);
        ws <= 4'hF;
        rdc(12'h020, 32'h0, 2'h0);
        wr(12'h018, 32'h10);
        $display("interrupt mode done");
        // disabling drops the latch and blanks the status
        wr(12'h100, 32'h59); wr(12'h100, 32'h16); wr(12'h100, 32'h88);
        wr(12'h018, 32'h6);
        mv <= 16'h0FA0;
        repeat (4) @(posedge aclk);
        check(birq, 1'b0);
        rdc(12'h018, 32'h6, 2'h0);
        // reset mode with supply already low
        wr(12'h018, 32'hF);
        repeat (4) @(posedge aclk);
        check(crst, 1'b1);
        check(birq, 1'b0);
        rdc(12'h018, 32'h5F, 2'h0);
        mv <= 16'h1388;
        repeat (4) @(posedge aclk);
        check(crst, 1'b0);
        $display("reset mode done");
        // second reset in mid-run, configuration word picks reset mode
        cfg <= 32'h00B00000;
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (3) @(posedge aclk);
        rdc(12'h018, 32'hB, 2'h0);
        rdc(12'h100, 32'h0, 2'h0);
        mv <= 16'h09C4;
        repeat (4) @(posedge aclk);
        check(crst, 1'b1);
        check(birq, 1'b0);
        $display("second reset done");
        test_done();
    end
endmodule
`default_nettype wire
